/* File: src/wsw_pkg.sv */
// Shared constants, register map and helper functions of the windowed safety watchdog.
package wsw_pkg;

  // Clock and time base.
  localparam int CLK_HZ         = 50_000_000;
  localparam int MS_PER_S       = 1000;
  localparam int MS_CYCLES      = CLK_HZ / MS_PER_S;
  localparam int INIT_WINDOW_MS = 1024;

  // Register offsets on the register port.
  localparam int          ADDR_W       = 4;
  localparam logic [3:0]  SEED_OFS     = 4'h0;
  localparam logic [3:0]  ANSWER_OFS   = 4'h1;
  localparam logic [3:0]  CONFIG_OFS   = 4'h2;
  localparam logic [3:0]  STATUS_OFS   = 4'h3;
  localparam logic [3:0]  DIAG_OFS     = 4'h4;
  localparam logic [3:0]  QUESTION_OFS = 4'h5;

  // Field positions.
  localparam int CFG_WIN_LSB   = 0;
  localparam int CFG_ERR_LSB   = 4;
  localparam int CFG_RFR_LSB   = 6;
  localparam int CFG_REACT_LSB = 8;
  localparam int STAT_VALUE    = 0;
  localparam int STAT_TIMING   = 1;
  localparam int STAT_HOSTREQ  = 2;
  localparam int DIAG_ERR_LSB  = 0;
  localparam int DIAG_RFR_LSB  = 4;

  // Values after reset.
  localparam logic [3:0]  WIN_RST      = 4'h3;
  localparam logic [1:0]  ERR_CEIL_RST = 2'h1;
  localparam logic [1:0]  RFR_CEIL_RST = 2'h0;
  localparam logic [15:0] DEFAULT_SEED = 16'h5ab2;

  // Seed values that are refused: zero always, all-ones in the simple scheme only.
  localparam logic [15:0] SEED_ZERO = 16'h0000;
  localparam logic [15:0] SEED_ONES = 16'hffff;

  // Question generator and answer transform.
  localparam logic [15:0] LFSR_TAPS   = 16'hb400;
  localparam logic [15:0] ANSWER_MASK = 16'hffff;

  // Failure reaction codes.
  localparam logic [1:0] REACT_STARTUP = 2'h1;
  localparam logic [1:0] REACT_DEEP    = 2'h2;

  // Window length in ms for each window code; zero means no supervision.
  function automatic logic [10:0] window_ms(input logic [3:0] code);
    case (code)
      4'h0:    window_ms = 11'd0;
      4'h1:    window_ms = 11'd1;
      4'h2:    window_ms = 11'd2;
      4'h3:    window_ms = 11'd3;
      4'h4:    window_ms = 11'd4;
      4'h5:    window_ms = 11'd6;
      4'h6:    window_ms = 11'd8;
      4'h7:    window_ms = 11'd12;
      4'h8:    window_ms = 11'd16;
      4'h9:    window_ms = 11'd24;
      4'ha:    window_ms = 11'd32;
      4'hb:    window_ms = 11'd64;
      4'hc:    window_ms = 11'd128;
      4'hd:    window_ms = 11'd256;
      4'he:    window_ms = 11'd512;
      default: window_ms = 11'd1024;
    endcase
  endfunction : window_ms

  function automatic logic [4:0] err_ceiling(input logic [1:0] code);
    case (code)
      2'h0:    err_ceiling = 5'd8;
      2'h1:    err_ceiling = 5'd6;
      2'h2:    err_ceiling = 5'd4;
      default: err_ceiling = 5'd2;
    endcase
  endfunction : err_ceiling

  function automatic logic [2:0] rfr_ceiling(input logic [1:0] code);
    case (code)
      2'h0:    rfr_ceiling = 3'd6;
      2'h1:    rfr_ceiling = 3'd4;
      2'h2:    rfr_ceiling = 3'd2;
      default: rfr_ceiling = 3'd1;
    endcase
  endfunction : rfr_ceiling

  // Answer expected for a question in the challenger scheme; mask is a parameter of the model.
  function automatic logic [15:0] expected_answer(input logic [15:0] question, input logic [15:0] mask);
    expected_answer = {question[7:0], question[15:8]} ^ mask;
  endfunction : expected_answer

endpackage : wsw_pkg

/* File: src/wsw_question_lfsr.sv */
// Sixteen-bit Galois shift register that produces the question word.
`timescale 1ns/10ps
module wsw_question_lfsr #(
  parameter logic [15:0] TAPS = wsw_pkg::LFSR_TAPS,
  parameter logic [15:0] INIT = wsw_pkg::DEFAULT_SEED
) (
  // Clock and reset.
  input  logic        clk,
  input  logic        sys_rst,
  // Control.
  input  logic        load,
  input  logic [15:0] loadValue,
  input  logic        step,
  // State.
  output logic [15:0] question
);

  logic [15:0] state_q;
  logic [15:0] stepped;

  assign stepped  = state_q[0] ? ((state_q >> 1) ^ TAPS) : (state_q >> 1);
  assign question = state_q;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      state_q <= INIT;
    else if (load)
      state_q <= loadValue;
    else if (step)
      state_q <= stepped;
  end

endmodule : wsw_question_lfsr

/* File: src/wsw_window_timer.sv */
// Window timer: closed half, then open half, or an initial window open throughout, counted in half-millisecond ticks.
`timescale 1ns/10ps
module wsw_window_timer #(
  parameter int HALF_MS_CYCLES = wsw_pkg::MS_CYCLES / 2
) (
  // Clock and reset.
  input  logic        clk,
  input  logic        sys_rst,
  // Control.
  input  logic        restart,
  input  logic        initial_,
  input  logic [10:0] lenMs,
  // Status.
  output logic        isOpen,
  output logic        timeout
);

  typedef enum logic [1:0] {PH_IDLE, PH_CLOSED, PH_OPEN} wsw_phase_t;

  wsw_phase_t  phase_q;
  logic [31:0] presc_q;
  logic [11:0] halfCnt_q;
  logic [11:0] closedHalves_q;
  logic [11:0] totalHalves_q;
  logic        tick;
  logic [11:0] halfNext;
  logic [11:0] initHalves;

  assign tick       = (presc_q == 32'(HALF_MS_CYCLES - 1));
  assign halfNext   = halfCnt_q + 12'd1;
  assign initHalves = 12'(2 * wsw_pkg::INIT_WINDOW_MS);
  assign isOpen     = (phase_q != PH_CLOSED);
  assign timeout    = (phase_q == PH_OPEN) && tick && (halfNext == totalHalves_q);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      phase_q        <= PH_IDLE;
      presc_q        <= 32'd0;
      halfCnt_q      <= 12'd0;
      closedHalves_q <= 12'd0;
      totalHalves_q  <= 12'd0;
    end
    else if (restart)
    begin
      presc_q   <= 32'd0;
      halfCnt_q <= 12'd0;
      if (initial_)
      begin
        closedHalves_q <= 12'd0;
        totalHalves_q  <= initHalves;
        phase_q        <= PH_OPEN;
      end
      else
      begin
        closedHalves_q <= {1'b0, lenMs};
        totalHalves_q  <= {lenMs, 1'b0};
        phase_q        <= (lenMs == 11'd0) ? PH_IDLE : PH_CLOSED;
      end
    end
    else
    begin
      case (phase_q)
        PH_IDLE:
          presc_q <= 32'd0;
        PH_CLOSED, PH_OPEN:
        begin
          presc_q <= tick ? 32'd0 : presc_q + 32'd1;
          if (tick)
          begin
            halfCnt_q <= halfNext;
            if (halfNext == closedHalves_q)
              phase_q <= PH_OPEN;
          end
        end
        default:
          phase_q <= PH_IDLE;
      endcase
    end
  end

endmodule : wsw_window_timer

/* File: src/wsw_watchdog.sv */
// Windowed safety watchdog with simple and challenger answer schemes.
`timescale 1ns/10ps
module wsw_watchdog #(
  parameter int          MS_CYCLES   = wsw_pkg::MS_CYCLES,
  parameter logic [15:0] ANSWER_MASK = wsw_pkg::ANSWER_MASK
) (
  // Clock and reset.
  input  logic        clk,
  input  logic        sys_rst,
  // Register port.
  input  logic [3:0]  regAddr,
  input  logic [15:0] regWrData,
  input  logic        regWrStb,
  input  logic        regRdStb,
  output logic [15:0] regRdData,
  // Fuses and system state.
  input  logic        challengerScheme,
  input  logic [1:0]  fusedFailureReaction,
  input  logic        startupCheck,
  // Watchdog results.
  output logic        windowOpen,
  output logic        failEvent,
  output logic        enterStartupCheck,
  output logic        enterDeepFailSafe,
  output logic        faultTallyDecrement
);

  // Register state.
  logic [3:0]  winCode_q;
  logic [1:0]  errCeilCode_q;
  logic [1:0]  rfrCeilCode_q;
  logic [1:0]  reaction_q;
  logic [2:0]  status_q;
  logic [3:0]  errTally_q;
  logic [2:0]  rfrTally_q;
  logic [15:0] rdData_q;
  logic        startPending_q;
  logic        windowOpen_q;
  logic        failEvent_q;
  logic        enterStartup_q;
  logic        enterDeep_q;
  logic        faultDec_q;

  // Decode and datapath.
  logic        wrSeed;
  logic        wrAnswer;
  logic        wrConfig;
  logic        wrStatus;
  logic        seedBad;
  logic        seedLate;
  logic        seedOk;
  logic        seedRefused;
  logic [15:0] question;
  logic [15:0] expected;
  logic        isOpen;
  logic        timeout;
  logic        good;
  logic        badValue;
  logic        badTiming;
  logic        bad;
  logic        restart;
  logic [4:0]  errCeil;
  logic [2:0]  rfrCeil;
  logic [4:0]  errStep;
  logic        errHit;
  logic        rfrHit;
  logic [3:0]  errTally_d;
  logic [2:0]  rfrTally_d;
  logic [2:0]  status_d;
  logic [15:0] configWord;
  logic [15:0] rdMux;

  assign wrSeed   = regWrStb && (regAddr == wsw_pkg::SEED_OFS);
  assign wrAnswer = regWrStb && (regAddr == wsw_pkg::ANSWER_OFS);
  assign wrConfig = regWrStb && (regAddr == wsw_pkg::CONFIG_OFS);
  assign wrStatus = regWrStb && (regAddr == wsw_pkg::STATUS_OFS);

  // Seed writes: zero is always refused, all-ones too in the simple scheme.
  assign seedBad     = (regWrData == wsw_pkg::SEED_ZERO)
                    || (!challengerScheme && (regWrData == wsw_pkg::SEED_ONES));
  assign seedLate    = challengerScheme && !startupCheck;
  assign seedOk      = wrSeed && !seedBad && !seedLate;
  assign seedRefused = wrSeed && !seedOk;

  // The same register holds the simple seed and the challenger question.
  wsw_question_lfsr #(
    .TAPS (wsw_pkg::LFSR_TAPS),
    .INIT (wsw_pkg::DEFAULT_SEED)
  ) u_lfsr (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .load      (seedOk),
    .loadValue (regWrData),
    .step      (good && challengerScheme),
    .question  (question)
  );

  // A pending start restarts with the long first window; a refresh or timeout with the chosen one.
  assign restart = startPending_q || wrAnswer || timeout;

  wsw_window_timer #(
    .HALF_MS_CYCLES (MS_CYCLES / 2)
  ) u_timer (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .restart  (restart),
    .initial_ (startPending_q),
    .lenMs    (wsw_pkg::window_ms(winCode_q)),
    .isOpen   (isOpen),
    .timeout  (timeout)
  );

  // Refresh judgement; a refresh in the last open cycle beats the timeout.
  assign expected  = challengerScheme ? wsw_pkg::expected_answer(question, ANSWER_MASK)
                                      : question;
  assign good      = wrAnswer && isOpen && (regWrData == expected);
  assign badValue  = wrAnswer && isOpen && (regWrData != expected);
  assign badTiming = (wrAnswer && !isOpen) || (timeout && !wrAnswer);
  assign bad       = badValue || badTiming;

  // Error tally steps up by two and down by one.
  assign errCeil    = wsw_pkg::err_ceiling(errCeilCode_q);
  assign errStep    = bad  ? {1'b0, errTally_q} + 5'd2
                    : good ? ((errTally_q == 4'd0) ? 5'd0 : {1'b0, errTally_q} - 5'd1)
                    : {1'b0, errTally_q};
  assign errHit     = (good || bad) && (errStep >= errCeil);
  assign errTally_d = errHit ? 4'd0 : errStep[3:0];

  // Good-refresh tally.
  assign rfrCeil    = wsw_pkg::rfr_ceiling(rfrCeilCode_q);
  assign rfrHit     = good && (rfrTally_q >= rfrCeil);
  assign rfrTally_d = bad    ? 3'd0
                    : rfrHit ? 3'd0
                    : good   ? rfrTally_q + 3'd1
                    : rfrTally_q;

  // Sticky flags: write one clears, a new event in the same cycle wins.
  assign status_d = (status_q & ~(wrStatus ? regWrData[2:0] : 3'd0))
                  | {seedRefused, badTiming, badValue};

  assign configWord = {6'd0, reaction_q, rfrCeilCode_q, errCeilCode_q, winCode_q};

  assign rdMux = (regAddr == wsw_pkg::SEED_OFS)     ? question
               : (regAddr == wsw_pkg::QUESTION_OFS) ? question
               : (regAddr == wsw_pkg::CONFIG_OFS)   ? configWord
               : (regAddr == wsw_pkg::STATUS_OFS)   ? {13'd0, status_q}
               : (regAddr == wsw_pkg::DIAG_OFS)     ? {9'd0, rfrTally_q, errTally_q}
               : 16'h0000;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      winCode_q     <= wsw_pkg::WIN_RST;
      errCeilCode_q <= wsw_pkg::ERR_CEIL_RST;
      rfrCeilCode_q <= wsw_pkg::RFR_CEIL_RST;
      reaction_q    <= 2'h0;
    end
    else if (startPending_q)
      reaction_q    <= fusedFailureReaction;
    else if (wrConfig)
    begin
      winCode_q     <= regWrData[wsw_pkg::CFG_WIN_LSB +: 4];
      errCeilCode_q <= regWrData[wsw_pkg::CFG_ERR_LSB +: 2];
      rfrCeilCode_q <= regWrData[wsw_pkg::CFG_RFR_LSB +: 2];
      reaction_q    <= regWrData[wsw_pkg::CFG_REACT_LSB +: 2];
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      startPending_q <= 1'b1;
      status_q       <= 3'd0;
      errTally_q     <= 4'd0;
      rfrTally_q     <= 3'd0;
    end
    else
    begin
      startPending_q <= 1'b0;
      status_q       <= status_d;
      errTally_q     <= errTally_d;
      rfrTally_q     <= rfrTally_d;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rdData_q       <= 16'h0000;
      windowOpen_q   <= 1'b0;
      failEvent_q    <= 1'b0;
      enterStartup_q <= 1'b0;
      enterDeep_q    <= 1'b0;
      faultDec_q     <= 1'b0;
    end
    else
    begin
      rdData_q       <= regRdStb ? rdMux : 16'h0000;
      windowOpen_q   <= isOpen;
      failEvent_q    <= errHit;
      enterStartup_q <= errHit && (reaction_q == wsw_pkg::REACT_STARTUP);
      enterDeep_q    <= errHit && (reaction_q == wsw_pkg::REACT_DEEP);
      faultDec_q     <= rfrHit;
    end
  end

  assign regRdData           = rdData_q;
  assign windowOpen          = windowOpen_q;
  assign failEvent           = failEvent_q;
  assign enterStartupCheck   = enterStartup_q;
  assign enterDeepFailSafe   = enterDeep_q;
  assign faultTallyDecrement = faultDec_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence goodAtCeiling_s;
    good && (rfrTally_q >= rfrCeil);
  endsequence

  sequence failAtCeiling_s;
    (good || bad) && (errStep >= errCeil);
  endsequence

  err_step_up_a: assert property (bad && !errHit |=> errTally_q == $past(errTally_q) + 4'd2)
    else $error("error tally did not rise by two");
  err_step_down_a: assert property (good && !errHit && errTally_q != 4'd0 |=>
    errTally_q == $past(errTally_q) - 4'd1)
    else $error("error tally did not fall by one");
  fail_clear_a: assert property (failAtCeiling_s |=> errTally_q == 4'd0 && failEvent_q)
    else $error("failure did not clear tally and pulse");
  fail_react_a: assert property ((failAtCeiling_s and (reaction_q == wsw_pkg::REACT_DEEP)) |=>
    enterDeepFailSafe && !enterStartupCheck)
    else $error("deep fail-safe reaction missing");
  seed_refuse_a: assert property (wrSeed && !challengerScheme && regWrData == 16'hffff |=>
    question == $past(question) && status_q[2])
    else $error("all-ones seed was not refused");
  lfsr_hold_a: assert property (bad && !seedOk |=> question == $past(question))
    else $error("question changed after bad refresh");
  lfsr_step_a: assert property (good && challengerScheme |=> question != $past(question))
    else $error("question did not advance");
  good_clear_a: assert property (bad |=> rfrTally_q == 3'd0 && !faultTallyDecrement)
    else $error("good tally not cleared by bad refresh");
  tally_dec_a: assert property (goodAtCeiling_s |=> faultTallyDecrement && rfrTally_q == 3'd0)
    else $error("fault tally decrement missing");
  value_flag_a: assert property (badValue |=> status_q[0] ##1 status_q[0] || $past(wrStatus))
    else $error("value fault flag not set");
  closed_bad_a: assert property (wrAnswer && !isOpen |=> status_q[1] && !windowOpen)
    else $error("closed refresh not flagged or window not closed");

  // A refresh, except in the cycle of a pending start, opens a new window with its closed part, unless the window code is zero.
  refresh_close_a: assert property (wrAnswer && !startPending_q && winCode_q != 4'h0 |=> !isOpen)
    else $error("refresh did not start a closed part");
  good_count_a: assert property (good && !rfrHit |=> rfrTally_q == $past(rfrTally_q) + 3'd1)
    else $error("good tally did not rise by one");
  first_window_a: assert property (startPending_q |=> isOpen ##1 windowOpen)
    else $error("first window after start is not open");
  timing_flag_a: assert property (badTiming |=> status_q[1])
    else $error("timing fault flag not set");
  seed_zero_a: assert property (wrSeed && regWrData == 16'h0000 |=>
    question == $past(question) && status_q[2])
    else $error("zero seed was not refused");

endmodule : wsw_watchdog

/* File: test/wsw_host_model.sv */
// Host model: drives the register port and works out refresh answers.
`timescale 1ns/10ps
module wsw_host_model #(
  parameter logic [15:0] MASK = wsw_pkg::ANSWER_MASK
) (
  // Clock and scheme.
  input  logic        clk,
  input  logic        challengerScheme,
  // Register port.
  output logic [3:0]  regAddr,
  output logic [15:0] regWrData,
  output logic        regWrStb,
  output logic        regRdStb,
  input  logic [15:0] regRdData
);
  initial
  begin
    regAddr   = 4'h0;
    regWrData = 16'h0000;
    regWrStb  = 1'b0;
    regRdStb  = 1'b0;
  end

  // Simple scheme echoes the seed; challenger swaps bytes and applies the mask.
  function automatic logic [15:0] answer_for(input logic [15:0] q);
    answer_for = challengerScheme ? ({q[7:0], q[15:8]} ^ MASK) : q;
  endfunction : answer_for

  // Write data is inverted after the strobe so stale data never looks valid.
  task automatic write_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr   <= a;
    regWrData <= d;
    regWrStb  <= 1'b1;
    @(posedge clk);
    regWrStb  <= 1'b0;
    regWrData <= ~d;
  endtask : write_reg

  task automatic read_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    regAddr  <= a;
    regRdStb <= 1'b1;
    @(posedge clk);
    regRdStb <= 1'b0;
    #1;
    d = regRdData;
  endtask : read_reg

  // A wrong answer flips the lowest bit of the right one.
  task automatic refresh(input logic [15:0] q, input logic wrong);
    write_reg(wsw_pkg::ANSWER_OFS, answer_for(q) ^ {15'h0000, wrong});
  endtask : refresh
endmodule : wsw_host_model

/* File: test/tb.sv */
// Self-checking bench of the windowed safety watchdog.
`timescale 1ns/10ps
module tb;
  localparam int         MS     = 20;
  localparam logic [3:0] A_SEED = wsw_pkg::SEED_OFS;
  localparam logic [3:0] A_CFG  = wsw_pkg::CONFIG_OFS;
  localparam logic [3:0] A_STAT = wsw_pkg::STATUS_OFS;
  localparam logic [3:0] A_DIAG = wsw_pkg::DIAG_OFS;
  localparam logic [3:0] A_QUES = wsw_pkg::QUESTION_OFS;

  logic        clk                  = 1'b0;
  logic        sys_rst              = 1'b1;
  logic        challengerScheme     = 1'b0;
  logic [1:0]  fusedFailureReaction = 2'h1;
  logic        startupCheck         = 1'b0;
  logic [3:0]  regAddr;
  logic [15:0] regWrData;
  logic        regWrStb;
  logic        regRdStb;
  logic [15:0] regRdData;
  logic        windowOpen;
  logic        failEvent;
  logic        enterStartupCheck;
  logic        enterDeepFailSafe;
  logic        faultTallyDecrement;
  int          miscompares = 0;
  int          comparisons = 0;
  int          nFail;
  int          nStart;
  int          nDeep;
  int          nDec;
  int          waited;

  always #10 clk = ~clk;

  wsw_watchdog #(.MS_CYCLES(MS)) wsw_watchdog_i (
    .clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .challengerScheme(challengerScheme), .fusedFailureReaction(fusedFailureReaction),
    .startupCheck(startupCheck), .windowOpen(windowOpen), .failEvent(failEvent),
    .enterStartupCheck(enterStartupCheck), .enterDeepFailSafe(enterDeepFailSafe),
    .faultTallyDecrement(faultTallyDecrement)
  );

  wsw_host_model wsw_host_model_i (
    .clk(clk), .challengerScheme(challengerScheme), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData)
  );

  task automatic end_sim;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
    begin
      $display("Simulation passed");
    end
    else
    begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk_reg(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_reg

  task automatic chk_cnt(input string name, input int exp, input int got);
    comparisons++;
    if (got != exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %0d seen %0d", name, exp, got);
    end
  endtask : chk_cnt

  task automatic do_reset(input logic scheme, input logic [1:0] fuse, input logic startup);
    @(posedge clk);
    sys_rst              <= 1'b1;
    challengerScheme     <= scheme;
    fusedFailureReaction <= fuse;
    startupCheck         <= startup;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
  endtask : do_reset

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    wsw_host_model_i.write_reg(a, d);
  endtask : wr

  task automatic rf(input logic [15:0] q, input logic wrong);
    wsw_host_model_i.refresh(q, wrong);
  endtask : rf

  task automatic expect_reg(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] d;
    wsw_host_model_i.read_reg(a, d);
    chk_reg($sformatf("register %h", a), exp, d);
  endtask : expect_reg

  task automatic wait_open(input int limit);
    waited = 0;
    #1;
    while (windowOpen !== 1'b1)
    begin
      @(posedge clk);
      #1;
      waited++;
      if (waited > limit)
      begin
        miscompares++;
        $display("CHECK FAILED windowOpen expected 1 seen 0");
        end_sim();
      end
    end
  endtask : wait_open

  // Counts pulses from just after the accepting edge on, so either pulse latency is seen.
  task automatic count_pulses(input int n);
    nFail  = 0;
    nStart = 0;
    nDeep  = 0;
    nDec   = 0;
    repeat (n)
    begin
      #1;
      nFail  += int'(failEvent === 1'b1);
      nStart += int'(enterStartupCheck === 1'b1);
      nDeep  += int'(enterDeepFailSafe === 1'b1);
      nDec   += int'(faultTallyDecrement === 1'b1);
      @(posedge clk);
    end
  endtask : count_pulses

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    lfsr_next = (v >> 1) ^ (v[0] ? wsw_pkg::LFSR_TAPS : 16'h0000);
  endfunction : lfsr_next

  initial
  begin
    do_reset(1'b0, 2'h1, 1'b0);
    expect_reg(A_CFG, 16'h0113);
    expect_reg(A_DIAG, 16'h0000);
    expect_reg(A_SEED, wsw_pkg::DEFAULT_SEED);
    expect_reg(4'hf, 16'h0000);
    for (int i = 0; i < 2; i++)
    begin
      wr(A_SEED, (i == 1) ? wsw_pkg::SEED_ONES : wsw_pkg::SEED_ZERO);
      expect_reg(A_STAT, 16'h0004);
      expect_reg(A_SEED, wsw_pkg::DEFAULT_SEED);
      wr(A_STAT, 16'h0007);
    end
    wr(A_SEED, 16'h1234);
    expect_reg(A_QUES, 16'h1234);
    expect_reg(A_STAT, 16'h0000);
    $display("test seed refusal done");
    // Window 1 ms, error ceiling 4, good ceiling 1, startup reaction.
    wr(A_CFG, 16'h01e1);
    rf(16'h1234, 1'b0);
    repeat (2) @(posedge clk);
    #1;
    chk_reg("windowOpen", 16'h0000, {15'h0000, windowOpen});
    wait_open(40);
    chk_cnt("closed cycles", 1, int'(waited >= MS / 2 - 3 && waited <= MS / 2));
    expect_reg(A_DIAG, 16'h0010);
    rf(16'h1234, 1'b0);
    count_pulses(4);
    chk_cnt("decrement pulses", 1, nDec);
    expect_reg(A_DIAG, 16'h0000);
    wait_open(20);
    rf(16'h1234, 1'b0);
    expect_reg(A_DIAG, 16'h0010);
    wait_open(20);
    rf(16'h1234, 1'b1);
    expect_reg(A_DIAG, 16'h0002);
    expect_reg(A_STAT, 16'h0001);
    wait_open(20);
    rf(16'h1234, 1'b0);
    expect_reg(A_DIAG, 16'h0011);
    rf(16'h1234, 1'b0);
    expect_reg(A_DIAG, 16'h0003);
    expect_reg(A_STAT, 16'h0003);
    count_pulses(30);
    chk_cnt("fail pulses", 1, nFail);
    chk_cnt("startup pulses", 1, nStart);
    chk_cnt("deep pulses", 0, nDeep);
    expect_reg(A_DIAG, 16'h0000);
    for (int r = 0; r < 4; r++)
    begin
      wr(A_CFG, {6'h00, 2'(r), 8'hf1});
      wait_open(20);
      rf(16'h1234, 1'b1);
      count_pulses(4);
      chk_cnt("fail pulses", 1, nFail);
      chk_cnt("startup pulses", int'(r == 1), nStart);
      chk_cnt("deep pulses", int'(r == 2), nDeep);
    end
    $display("test simple scheme tallies done");
    do_reset(1'b1, 2'h2, 1'b1);
    repeat (1000) @(posedge clk);
    #1;
    chk_reg("windowOpen", 16'h0001, {15'h0000, windowOpen});
    expect_reg(A_QUES, wsw_pkg::DEFAULT_SEED);
    expect_reg(A_CFG, 16'h0213);
    wr(A_SEED, wsw_pkg::SEED_ZERO);
    expect_reg(A_STAT, 16'h0004);
    expect_reg(A_QUES, wsw_pkg::DEFAULT_SEED);
    wr(A_STAT, 16'h0007);
    wr(A_SEED, wsw_pkg::SEED_ONES);
    expect_reg(A_QUES, 16'hffff);
    @(posedge clk);
    startupCheck <= 1'b0;
    wr(A_SEED, 16'h1111);
    expect_reg(A_QUES, 16'hffff);
    rf(16'hffff, 1'b1);
    expect_reg(A_QUES, 16'hffff);
    expect_reg(A_DIAG, 16'h0002);
    wait_open(40);
    rf(16'hffff, 1'b0);
    expect_reg(A_QUES, lfsr_next(16'hffff));
    expect_reg(A_DIAG, 16'h0011);
    $display("test challenger scheme done");
    end_sim();
  end
endmodule : tb
